// >>> src/psr_regs.vh
`ifndef PSR_REGS_VH
`define PSR_REGS_VH

// ****************************************************************
// Register offsets (byte addresses on the register bus)
// ****************************************************************
`define OFS_COMBINED 8'h00
`define OFS_EXEC_VIEW 8'h04
`define OFS_INTNUM_VIEW 8'h08
`define OFS_FAULT_CTRL 8'h0C
`define OFS_FAULT_STAT 8'h10

// ****************************************************************
// Field positions in the combined status word and the fault control/status registers
// ****************************************************************
`define BIT_ISA 24
`define ES_HI_MSB 26
`define ES_HI_LSB 25
`define ES_LO_MSB 15
`define ES_LO_LSB 10
`define EXC_MSB 5
`define EXC_LSB 0
`define CTRL_LOCKUP_BIT 0
`define STAT_FAULT_BIT 0
`define STAT_LOCKUP_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define ISA_RST 1'b1
`define ES_RST 8'h00
`define EXC_RST 6'h00
`define CTRL_RST 1'b0

// ****************************************************************
// Exception kinds from the core and their reported codes
// ****************************************************************
`define KIND_THREAD 4'h0
`define KIND_NMI 4'h1
`define KIND_HARD 4'h2
`define KIND_MEM 4'h3
`define KIND_BUS 4'h4
`define KIND_USAGE 4'h5
`define KIND_SVC 4'h6
`define KIND_DEFERRED_SERVICE_CALL 4'h7
`define KIND_TICK 4'h8
`define KIND_IRQ 4'h9
`define EXC_THREAD 6'h00
`define EXC_NMI 6'h02
`define EXC_HARD 6'h03
`define EXC_MEM 6'h04
`define EXC_BUS 6'h05
`define EXC_USAGE 6'h06
`define EXC_SVC 6'h0B
`define EXC_DEFERRED_SERVICE_CALL 6'h0E
`define EXC_TICK 6'h0F
`define EXC_IRQ_BASE 6'h10
`define EXC_IRQ_LAST 6'h2D
`define IRQ_MAX 5'h1D

`endif

// >>> src/exc_num_encoder.v
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"

module exc_num_encoder (
    // Exception request from the core
    input wire [3:0] kind,
    input wire [4:0] irq_index,
    // Encoded number
    output reg [5:0] code,
    output reg code_ok
);

    // Map kind to code; unknown kinds and vectors past 29 are refused
    always @*
    begin
        code = `EXC_THREAD;
        code_ok = 1'b1;
        case (kind)
            `KIND_THREAD: code = `EXC_THREAD;
            `KIND_NMI: code = `EXC_NMI;
            `KIND_HARD: code = `EXC_HARD;
            `KIND_MEM: code = `EXC_MEM;
            `KIND_BUS: code = `EXC_BUS;
            `KIND_USAGE: code = `EXC_USAGE;
            `KIND_SVC: code = `EXC_SVC;
            `KIND_DEFERRED_SERVICE_CALL: code = `EXC_DEFERRED_SERVICE_CALL;
            `KIND_TICK: code = `EXC_TICK;
            `KIND_IRQ:
            begin
                code = `EXC_IRQ_BASE + {1'b0, irq_index};
                code_ok = (irq_index <= `IRQ_MAX);
            end
            default: code_ok = 1'b0;
        endcase
    end

endmodule // exc_num_encoder
`default_nettype wire

// >>> src/pred_block_tracker.v
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"

module pred_block_tracker (
    // Current split state
    input wire [7:0] es,
    input wire ici_mode,
    // Block prefix fields
    input wire [3:0] first_cond,
    input wire [3:0] cond_mask,
    // Derived state
    output wire active,
    output wire [3:0] cond,
    output wire [7:0] es_start,
    output wire [7:0] es_advance
);

    // Block is live while the mask bits are non-zero and no resume state is held
    assign active = ~ici_mode & (es[3:0] != 4'h0);
    // Top three bits are the base condition, bit 4 flips it per slot
    assign cond = es[7:4];
    assign es_start = {first_cond, cond_mask};
    // Shift the mask after each instruction; the last slot ends the block
    assign es_advance = (es[2:0] == 3'h0) ? `ES_RST :
        {es[7:5], es[3:0], 1'b0};

endmodule // pred_block_tracker
`default_nettype wire

// >>> src/processor_status_fields.v
`timescale 1ns/1ps
`default_nettype none
`include "psr_regs.vh"

// Summary of operation
// - ISA state flag at bit 24, resets set
// - Exchange branches and pop-to-pc update flag
// - Exception return reloads flag from stacked image
// - Entry and reset load flag from vector bit0
// - Execution with flag clear faults or locks up
// - Resume/predicate state split, read-only, resets zero
// - Interrupted multi-transfer records next register number
// - Resume multi-transfer at recorded register
// - Resume state forces low split bits zero
// - Track up to four predicated instructions
// - Block conditions identical or inverse
// - Bits 5:0 report active exception number
// - Exception number only in combined/number views

module processor_status_fields (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output reg [31:0] hrdata,
    output wire hresp,
    // Exchange branches
    input wire xchg_valid,
    input wire xchg_target_lsb,
    // Vector fetch on reset or exception entry
    input wire vec_valid,
    input wire vec_lsb,
    input wire [3:0] vec_kind,
    input wire [4:0] vec_irq,
    // Exception return
    input wire ret_valid,
    input wire [31:0] ret_image,
    // Multi-register transfers
    input wire multi_pause,
    input wire [3:0] multi_next_reg,
    input wire multi_done,
    output wire multi_resume_valid,
    output wire [3:0] multi_resume_reg,
    // Predicated blocks
    input wire pred_start,
    input wire [3:0] pred_first_cond,
    input wire [3:0] pred_mask,
    input wire instr_retire,
    output wire pred_active,
    output wire [3:0] pred_cond,
    // Instruction issue check
    input wire instr_issue,
    output reg isa_fault,
    output wire lockup,
    output wire exec_ok,
    // Status word for stacking
    output wire [31:0] status_word
);

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Instruction-set flag and split continuation/predication field
    reg isa_r;
    reg isa_nxt;
    reg [7:0] es_r;
    reg [7:0] es_nxt;
    reg ici_r;
    reg ici_nxt;
    // Active exception number
    reg [5:0] exc_r;
    reg [5:0] exc_nxt;
    // Fault control, sticky status and lockup
    reg lock_en_r;
    reg fault_seen_r;
    reg lockup_r;
    reg isa_fault_nxt;

    // ****************************************************************
    // Bus slave state
    // ****************************************************************
    // Write address held over into the data phase
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    // Decoded address phase
    wire take;
    wire [7:0] ofs;
    wire wr_ctrl;
    wire wr_stat;

    // ****************************************************************
    // Helper outputs
    // ****************************************************************
    // Encoder and tracker results
    wire [5:0] vec_code;
    wire vec_code_ok;
    wire [7:0] es_start;
    wire [7:0] es_adv;
    // Word views and stacked image fields
    wire [31:0] exec_view;
    wire [31:0] num_view;
    wire [5:0] ret_code;
    wire [7:0] ret_es;
    wire ret_code_ok;
    wire ret_ici;

    // A refused kind keeps the number already reported
    exc_num_encoder u_enc (
        .kind(vec_kind),
        .irq_index(vec_irq),
        .code(vec_code),
        .code_ok(vec_code_ok)
    );

    // Predicated block state lives in the split field
    pred_block_tracker u_pred (
        .es(es_r),
        .ici_mode(ici_r),
        .first_cond(pred_first_cond),
        .cond_mask(pred_mask),
        .active(pred_active),
        .cond(pred_cond),
        .es_start(es_start),
        .es_advance(es_adv)
    );

    // ****************************************************************
    // Checks on the stacked image
    // ****************************************************************

    // A restored number must be one that could have been reported
    function code_valid;
        input [5:0] c;
        begin
            code_valid = (c == `EXC_THREAD) || (c == `EXC_SVC) ||
                ((c >= `EXC_NMI) && (c <= `EXC_USAGE)) ||
                ((c >= `EXC_DEFERRED_SERVICE_CALL) && (c <= `EXC_IRQ_LAST));
        end
    endfunction

    // Stacked image fields, split the same way as the live word
    assign ret_code = ret_image[`EXC_MSB:`EXC_LSB];
    assign ret_code_ok = code_valid(ret_code);
    assign ret_es = {ret_image[`ES_LO_MSB:`ES_LO_LSB],
        ret_image[`ES_HI_MSB:`ES_HI_LSB]};
    // Image holds resume state when a register number sits with empty low bits
    assign ret_ici = (ret_es[3:0] == 4'h0) && (ret_es[7:4] != 4'h0);

    // ****************************************************************
    // Execution state next value
    // ****************************************************************

    // Vector load has top priority, then return, then in-flight events
    always @*
    begin
        isa_nxt = isa_r;
        es_nxt = es_r;
        ici_nxt = ici_r;
        exc_nxt = exc_r;
        if (vec_valid)
        begin
            isa_nxt = vec_lsb;
            es_nxt = `ES_RST;
            ici_nxt = 1'b0;
            if (vec_code_ok)
                exc_nxt = vec_code;
        end
        else if (ret_valid)
        begin
            isa_nxt = ret_image[`BIT_ISA];
            ici_nxt = ret_ici;
            // Resume state keeps only the register number
            es_nxt = ret_ici ? {ret_es[7:4], 4'h0} : ret_es;
            exc_nxt = ret_code_ok ? ret_code : `EXC_THREAD;
        end
        else
        begin
            // Exchange runs alongside the field updates below
            if (xchg_valid)
                isa_nxt = xchg_target_lsb;
            if (multi_pause)
            begin
                es_nxt = {multi_next_reg, 4'h0};
                ici_nxt = 1'b1;
            end
            else if (multi_done)
            begin
                es_nxt = `ES_RST;
                ici_nxt = 1'b0;
            end
            else if (pred_start)
            begin
                es_nxt = es_start;
                ici_nxt = 1'b0;
            end
            else if (instr_retire && pred_active)
                es_nxt = es_adv;
        end
    end

    // Hardware-only update; bus writes never reach these flops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            isa_r <= `ISA_RST;
            es_r <= `ES_RST;
            ici_r <= 1'b0;
            exc_r <= `EXC_RST;
        end
        else
        begin
            isa_r <= isa_nxt;
            es_r <= es_nxt;
            ici_r <= ici_nxt;
            exc_r <= exc_nxt;
        end
    end

    // ****************************************************************
    // Issue check with the state flag clear
    // ****************************************************************

    // Lockup is held until a vector load; a fault is a one-cycle pulse
    always @*
    begin
        isa_fault_nxt = 1'b0;
        if (instr_issue && !isa_r && !lock_en_r && !lockup_r)
            isa_fault_nxt = 1'b1;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            isa_fault <= 1'b0;
            lockup_r <= 1'b0;
        end
        else
        begin
            isa_fault <= isa_fault_nxt;
            if (instr_issue && !isa_r && lock_en_r)
                lockup_r <= 1'b1;
            else if (vec_valid)
                lockup_r <= 1'b0;
        end
    end

    // Lockup stands until the next vector load or reset
    assign lockup = lockup_r;
    // Core may only execute with the flag set and no lockup
    assign exec_ok = isa_r & ~lockup_r;

    // ****************************************************************
    // Views of the status word
    // ****************************************************************

    // Combined word: reserved bits and excluded flags read zero
    assign status_word = {5'h00, es_r[1:0], isa_r, 8'h00, es_r[7:2],
        4'h0, exc_r};
    // Execution view drops the number
    assign exec_view = {5'h00, es_r[1:0], isa_r, 8'h00, es_r[7:2], 10'h000};
    // Number view shows only bits 5:0
    assign num_view = {26'h0000000, exc_r};

    // Resume request to the core comes straight from the held state
    assign multi_resume_valid = ici_r;
    assign multi_resume_reg = es_r[7:4];

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel & htrans[1] & hready;
    assign ofs = haddr[7:0];

    // Address phase captured for the write data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_r <= take & hwrite;
            wr_addr_r <= ofs;
        end
    end

    // Read data registered in the address phase, shown in the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (take && !hwrite)
        begin
            case (ofs)
                `OFS_COMBINED: hrdata <= status_word;
                `OFS_EXEC_VIEW: hrdata <= exec_view;
                `OFS_INTNUM_VIEW: hrdata <= num_view;
                `OFS_FAULT_CTRL: hrdata <= {31'h00000000, lock_en_r};
                `OFS_FAULT_STAT: hrdata <= {30'h00000000, lockup_r, fault_seen_r};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Status-word offsets take no write: every field there is read-only
    assign wr_ctrl = wr_pend_r && (wr_addr_r == `OFS_FAULT_CTRL);
    assign wr_stat = wr_pend_r && (wr_addr_r == `OFS_FAULT_STAT);

    // Control bit selects lockup instead of a fault on a clear flag
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lock_en_r <= `CTRL_RST;
        else if (wr_ctrl)
            lock_en_r <= hwdata[`CTRL_LOCKUP_BIT];
    end

    // Sticky fault flag, write one to clear; a new fault wins the clear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fault_seen_r <= 1'b0;
        else if (isa_fault_nxt)
            fault_seen_r <= 1'b1;
        else if (wr_stat && hwdata[`STAT_FAULT_BIT])
            fault_seen_r <= 1'b0;
    end

endmodule // processor_status_fields
`default_nettype wire

// >>> verification/psf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module psf_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Core events
    input wire logic xchg_valid,
    input wire logic xchg_target_lsb,
    input wire logic vec_valid,
    input wire logic vec_lsb,
    input wire logic [3:0] vec_kind,
    input wire logic [4:0] vec_irq,
    input wire logic ret_valid,
    input wire logic [31:0] ret_image,
    input wire logic multi_pause,
    input wire logic multi_done,
    input wire logic [3:0] multi_next_reg,
    input wire logic pred_start,
    input wire logic [3:0] pred_first_cond,
    input wire logic instr_issue,
    // Observed state
    input wire logic multi_resume_valid,
    input wire logic [3:0] multi_resume_reg,
    input wire logic pred_active,
    input wire logic [3:0] pred_cond,
    input wire logic isa_fault,
    input wire logic lockup,
    input wire logic exec_ok,
    input wire logic [31:0] status_word
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Vector load and return outrank every core event but instr_issue, which still faults or locks up
    wire logic top_ev = vec_valid || ret_valid;
    wire logic [5:0] num = status_word[5:0];
    sequence s_pause;
        multi_pause && !top_ev && multi_next_reg != 4'h0;
    endsequence
    sequence s_pred;
        pred_start && !multi_pause && !multi_done && !top_ev;
    endsequence
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_vec;
        vec_valid |=> status_word[24] == $past(vec_lsb);
    endproperty
    property p_xchg;
        xchg_valid && !top_ev |=> status_word[24] == $past(xchg_target_lsb);
    endproperty
    property p_ret;
        ret_valid && !vec_valid |=> status_word[24] == $past(ret_image[24]);
    endproperty
    property p_fault;
        instr_issue && !status_word[24] && !lockup && !top_ev |=> isa_fault || lockup;
    endproperty
    property p_exec;
        exec_ok == (status_word[24] && !lockup);
    endproperty
    property p_rsvd;
        status_word[23:16] == 8'h00 && status_word[9:6] == 4'h0;
    endproperty
    property p_pause;
        s_pause |=> multi_resume_valid && multi_resume_reg == $past(multi_next_reg);
    endproperty
    property p_ici;
        multi_resume_valid |-> status_word[11:10] == 2'b00 && status_word[26:25] == 2'b00;
    endproperty
    property p_pred;
        s_pred |=> pred_active && pred_cond == $past(pred_first_cond);
    endproperty
    property p_irq;
        vec_valid && vec_kind == 4'h9 && vec_irq <= 5'h1D |=> num == 6'h10 + {1'b0, $past(vec_irq)};
    endproperty
    // Reserved codes must never show as an active handler
    property p_code;
        !(num == 6'h01 || (num >= 6'h07 && num <= 6'h0A) || num == 6'h0C
          || num == 6'h0D || num >= 6'h2E);
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus answer not ready or not okay");
    a_vec: assert property (p_vec)
        else $error("flag not loaded from vector");
    a_xchg: assert property (p_xchg)
        else $error("flag not loaded from branch target");
    a_ret: assert property (p_ret)
        else $error("flag not restored on return");
    a_fault: assert property (p_fault)
        else $error("issue with flag clear not faulted");
    a_exec: assert property (p_exec)
        else $error("exec_ok wrong");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");
    a_pause: assert property (p_pause)
        else $error("resume register not recorded");
    a_ici: assert property (p_ici)
        else $error("low split bits not zero in resume state");
    a_pred: assert property (p_pred)
        else $error("block not entered");
    a_irq: assert property (p_irq)
        else $error("vector number encoding wrong");
    a_code: assert property (p_code)
        else $error("reserved exception number reported");
endmodule // psf_chk
bind processor_status_fields psf_chk chk_u (.*);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk, hresetn, hsel, hwrite, rd_q, xchg_valid, xchg_target_lsb, vec_valid, vec_lsb;
    logic ret_valid, multi_pause, multi_done, pred_start, instr_retire, instr_issue;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] vec_kind, multi_next_reg, pred_first_cond, pred_mask, r, m, fc;
    logic [4:0] vec_irq, n;
    logic [31:0] haddr, hwdata, ret_image, exp_q[$];
    wire hreadyout, hresp, multi_resume_valid, pred_active, isa_fault, lockup, exec_ok;
    wire [3:0] multi_resume_reg, pred_cond;
    wire [31:0] hrdata, status_word;
    wire hready = hreadyout;
    int failures, comparisons;
    logic [5:0] codes [0:8] = '{6'h00, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h0B, 6'h0E, 6'h0F};

    processor_status_fields dut_u (.*);

    // ****************
    // Clock, monitor, tasks
    // ****************
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        chk(exp_q.size(), 32'h0);
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Read data is taken at the edge closing its data phase
    always @(posedge hclk)
    begin
        if (rd_q)
            chk(hrdata, exp_q.pop_front());
        rd_q <= hresetn && hsel && htrans[1] && !hwrite && hready;
    end
    // Bounded wait for hready sampled high
    task rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 50)
        begin
            k++;
            @(posedge hclk);
        end
        if (k == 50)
        begin
            failures++;
            end_of_test;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        if (!w)
            exp_q.push_back(d);
        rdy;
        htrans <= 2'b00;
        hsel <= 1'b0;
        if (w)
            hwdata <= d;
        rdy;
    endtask
    // Strobe order: xchg vec ret pause done pred retire issue
    task pulse(input logic [7:0] s);
        @(posedge hclk);
        {xchg_valid, vec_valid, ret_valid, multi_pause, multi_done, pred_start, instr_retire,
            instr_issue} <= s;
        @(posedge hclk);
        {xchg_valid, vec_valid, ret_valid, multi_pause, multi_done, pred_start, instr_retire,
            instr_issue} <= 8'h00;
        // One more edge so outputs of the strobed cycle are settled when read
        @(posedge hclk);
    endtask
    task vec(input logic [3:0] k, input logic [4:0] i);
        vec_kind <= k;
        vec_irq <= i;
        vec_lsb <= 1'b1;
        pulse(8'h40);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial
    begin
        {hresetn, hsel, hwrite, xchg_valid, xchg_target_lsb, vec_valid, vec_lsb} = 7'h00;
        {ret_valid, multi_pause, multi_done, pred_start, instr_retire, instr_issue} = 6'h00;
        {htrans, vec_kind, multi_next_reg, pred_first_cond, pred_mask, vec_irq} = 23'h000000;
        {haddr, hwdata, ret_image} = 96'h0;
        hsize = 3'h2;
        failures = 0;
        comparisons = 0;
        void'($urandom(32'h4ecc6ed0));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0100_0000);
        bus(1'b0, 8'h0C, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000);
        for (int k = 0; k < 9; k++)
        begin
            vec(k[3:0], 5'h00);
            bus(1'b0, 8'h00, 32'h0100_0000 | codes[k]);
            bus(1'b0, 8'h04, 32'h0100_0000);
            bus(1'b0, 8'h08, {26'h0, codes[k]});
        end
        for (int i = 0; i < 4; i++)
        begin
            n = (i == 0) ? 5'h1D : 5'($urandom_range(28, 0));
            vec(4'h9, n);
            bus(1'b0, 8'h08, 32'h10 + n);
        end
        vec(4'h9, 5'h1E);
        bus(1'b0, 8'h08, 32'h10 + n);
        vec(4'hC, 5'h00);
        bus(1'b0, 8'h08, 32'h10 + n);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF);
        bus(1'b1, 8'h08, 32'h0000_0000);
        bus(1'b0, 8'h00, 32'h0100_0010 + n);
        xchg_target_lsb <= 1'b0;
        pulse(8'h80);
        bus(1'b0, 8'h00, 32'h10 + n);
        pulse(8'h01);
        chk(isa_fault, 1'b1);
        bus(1'b0, 8'h10, 32'h1);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b1, 8'h0C, 32'h1);
        pulse(8'h01);
        chk({lockup, exec_ok}, 2'b10);
        vec(4'h3, 5'h00);
        chk({lockup, exec_ok}, 2'b01);
        ret_image <= 32'h0000_000F;
        pulse(8'h20);
        bus(1'b0, 8'h00, 32'h0000_000F);
        ret_image <= 32'h0100_0007;
        pulse(8'hA0);
        bus(1'b0, 8'h00, 32'h0100_0000);
        r = 4'($urandom_range(15, 1));
        multi_next_reg <= r;
        pulse(8'h10);
        chk({multi_resume_valid, multi_resume_reg}, {1'b1, r});
        bus(1'b0, 8'h00, 32'h0100_0000 | (r << 12));
        vec(4'h6, 5'h00);
        ret_image <= 32'h0100_0000 | (r << 12);
        pulse(8'h20);
        chk({multi_resume_valid, multi_resume_reg}, {1'b1, r});
        pulse(8'h08);
        chk(multi_resume_valid, 1'b0);
        // Block length follows the lowest set mask bit
        for (int len = 1; len <= 4; len++)
        begin
            m = (4'h1 << (4 - len)) | (4'($urandom) & (4'hF << (5 - len)));
            fc = 4'($urandom_range(13, 0));
            {pred_first_cond, pred_mask} <= {fc, m};
            pulse(8'h04);
            chk(pred_cond, fc);
            for (int j = 0; j < len; j++)
            begin
                chk({pred_active, pred_cond[3:1]}, {1'b1, fc[3:1]});
                pulse(8'h02);
            end
            chk(pred_active, 1'b0);
        end
        // Disturb the flag, split field and number so the mid-run reset has something to undo
        vec(4'h8, 5'h00);
        pulse(8'h90);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0100_0000);
        bus(1'b0, 8'h0C, 32'h0000_0000);
        chk({lockup, exec_ok, multi_resume_valid}, 3'b010);
        repeat (2) @(posedge hclk);
        end_of_test;
    end
endmodule // tb_top
`default_nettype wire
